// File: test/tfa_core_assertions.sv
// Bound protocol and fault checks for the translation fault unit
`timescale 1ns/1ps
module tfa_core_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pipeline
    input wire tfa_pkg::tfa_lookup_type lookup,
    input wire logic entry_load_instr,
    input wire tfa_pkg::tfa_fault_type fault_out,
    input wire logic [31:0] status_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shorthands for setup phase and fault fields
    wire setup = psel && !penable;
    wire [7:0] sel = paddr[31:24];
    wire f = fault_out.fault;
    wire [11:0] c = fault_out.code;
    chk_ready_next: assert property (setup |=> pready && penable) else $error("access not answered");
    chk_ready_only: assert property (pready |-> psel && penable && $past(setup)) else $error("stray ready");
    chk_refuse_priv: assert property (setup && !pprot[0] |=> pslverr) else $error("unprivileged accepted");
    chk_refuse_size: assert property (setup && pwrite && pstrb != 4'hF |=> pslverr) else $error("part word");
    chk_refuse_sel: assert property (setup && !(sel inside {8'hF2, 8'hF3, 8'hFF}) |=>
        pslverr && ($past(pwrite) || prdata == 32'h0))
        else $error("unmapped accepted");
    chk_row_zero: assert property (pready && !pwrite && !pslverr && sel == 8'hF2 |-> prdata[16:12] == 5'h00)
        else $error("index bits not zero");
    chk_load_code: assert property (f && !$past(lookup.write) |-> c inside {12'h040, 12'h0A0})
        else $error("bad load code");
    chk_store_code: assert property (f && $past(lookup.write) |-> c inside {12'h060, 12'h080, 12'h0C0})
        else $error("bad store code");
    chk_fault_cause: assert property (f |-> $past(lookup.valid)) else $error("fault without access");
    chk_status_set: assert property (f |-> status_out[30:28] == 3'h7) else $error("mode bits not set");
    // Main scenarios
    cov_invalid: cover property (f && c == 12'h040);
    cov_first: cover property (f && c == 12'h080);
    cov_prot: cover property (f && c == 12'h0C0);
    cov_refuse: cover property (pready && pslverr);
endmodule

bind tfa_core tfa_core_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lookup(lookup), .entry_load_instr(entry_load_instr),
    .fault_out(fault_out), .status_out(status_out));

// File: test/tfa_core_tb.sv
// Self-checking bench for the translation fault unit
`timescale 1ns/1ps
`include "tfa_defs.svh"
module tfa_core_tb;
    localparam logic [31:0] VA = 32'h0AB6_3C44;
    localparam logic [31:0] PC = 32'h8C00_1000;
    localparam logic [31:0] BP = 32'h8C00_0FFC;
    localparam logic [31:0] AA = 32'hF200_3100;
    localparam logic [31:0] DA = 32'hF300_3100;
    localparam logic [31:0] EH = 32'hFF00_0000;
    localparam logic [31:0] MC = 32'hFF00_0010;
    localparam logic [31:0] EV = 32'hFF00_0020;
    localparam logic [31:0] VB = 32'hFF00_0030;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [2:0] pprot = 3'h1;
    logic [31:0] prdata;
    logic pready, pslverr, issue = 1'b0, load_req = 1'b0, seen, entry_load_instr;
    logic [31:0] status_out;
    tfa_pkg::tfa_lookup_type req = '0;
    tfa_pkg::tfa_lookup_type lookup;
    tfa_pkg::tfa_fault_type fault_out;
    tfa_pkg::tfa_fault_type got;
    int mismatches = 0;
    int num_checks = 0;
    tfa_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lookup(lookup), .entry_load_instr(entry_load_instr), .fault_out(fault_out),
        .status_out(status_out));
    tfa_pipe_model i_pipe (.pclk(pclk), .presetn(presetn), .issue(issue), .load_req(load_req), .req(req),
        .lookup(lookup), .entry_load_instr(entry_load_instr), .fault_out(fault_out), .seen(seen), .got(got));
    // Clock
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic end_of_test;
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        num_checks++;
        if (seen_v !== exp_v) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    // One APB transfer, released only after ready is sampled
    task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
        input logic [2:0] p, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        pprot <= p;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, 4'hF, 3'h1, r, e);
        check(e, 1'b0);
    endtask
    task automatic rdv(input logic [31:0] a, output logic [31:0] r);
        logic e;
        apb(a, 1'b0, 32'h0, 4'hF, 3'h1, r, e);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] x);
        logic [31:0] r;
        rdv(a, r);
        check(r, x);
    endtask
    // Issue one access through the pipeline model and wait for its outcome
    task automatic look(input logic w, input logic sl, input logic ef);
        int n;
        @(posedge pclk);
        req <= '{valid: 1'b1, write: w, in_slot: sl, vaddr: VA, pc: PC, branch_pc: BP};
        issue <= 1'b1;
        @(posedge pclk);
        issue <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (seen !== 1'b1 && n < 6);
        check(seen, ef);
    endtask
    task automatic t_arrays;
        // Give the other ways of set 3 a known, non-matching page so lookups and associative writes see no unknowns
        wr(32'hF200_3000, 32'h0000_0000);
        wr(32'hF200_3200, 32'h0000_0000);
        wr(32'hF200_3300, 32'h0000_0000);
        wr(AA, 32'h0AB7_FD01);
        rd(AA, 32'h0AB6_0D01);
        wr(DA, 32'h0000_0012);
        rd(DA, 32'h0000_0012);
        rd(AA, 32'h0AB6_0C01);
    endtask
    task automatic t_invalid;
        logic [31:0] v;
        wr(VB, 32'h8000_0000);
        wr(MC, 32'h0000_0001);
        look(1'b0, 1'b0, 1'b1);
        check(got.code, `TFA_CODE_INVALID_LOAD);
        check(got.way, 2'h1);
        check(got.vector, 32'h8000_0100);
        rd(EV, `TFA_CODE_INVALID_LOAD);
        rd(32'hFF00_000C, VA);
        rd(32'hFF00_0024, PC);
        rd(32'hFF00_0028, `TFA_SR_RESET);
        rd(MC, 32'h0000_1001);
        rdv(EH, v);
        check(v[31:17], VA[31:17]);
        look(1'b1, 1'b1, 1'b1);
        check(got.code, `TFA_CODE_INVALID_STORE);
        rd(32'hFF00_0024, BP);
    endtask
    task automatic t_prot;
        wr(DA, 32'h0000_0112);
        wr(MC, 32'h0000_0001);
        look(1'b1, 1'b0, 1'b1);
        check(got.code, `TFA_CODE_PROT_STORE);
        rd(MC, 32'h0000_1001);
        wr(32'hFF00_002C, 32'h0000_00F0);
        look(1'b0, 1'b0, 1'b1);
        check(got.code, `TFA_CODE_PROT_LOAD);
        rd(32'hFF00_0028, 32'h0000_00F0);
        check(status_out[30:28], 3'h7);
    endtask
    task automatic t_first;
        wr(DA, 32'h0000_0132);
        wr(MC, 32'h0000_0001);
        look(1'b1, 1'b0, 1'b1);
        check(got.code, `TFA_CODE_FIRST_WRITE);
        rd(MC, 32'h0000_1001);
        look(1'b0, 1'b0, 1'b0);
        wr(32'hFF00_0004, 32'h0000_0136);
        @(posedge pclk);
        load_req <= 1'b1;
        @(posedge pclk);
        load_req <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(DA, 32'h0000_0136);
        look(1'b1, 1'b0, 1'b0);
    endtask
    task automatic t_assoc;
        wr(32'hF200_3080, 32'h0F00_0C01);
        rd(DA, 32'h0000_0136);
        wr(32'hF200_3080, 32'h0AB6_0C01);
        rd(DA, 32'h0000_0036);
    endtask
    task automatic t_refuse;
        logic [31:0] r;
        logic e;
        apb(32'hF400_0000, 1'b0, 32'h0, 4'hF, 3'h1, r, e);
        check(r, 32'h0000_0000);
        check(e, 1'b1);
        apb(DA, 1'b0, 32'h0, 4'hF, 3'h0, r, e);
        check(e, 1'b1);
        apb(32'hFF00_0040, 1'b0, 32'h0, 4'hF, 3'h1, r, e);
        check(e, 1'b1);
        apb(VB, 1'b1, 32'h1, 4'h3, 3'h1, r, e);
        check(e, 1'b1);
        rd(VB, 32'h8000_0000);
    endtask
    task automatic t_hash;
        wr(EH, 32'h0000_0005);
        wr(MC, 32'h0000_0201);
        wr(32'hF300_3200, 32'h0000_0012);
        wr(MC, 32'h0000_0001);
        rd(32'hF300_6200, 32'h0000_0012);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check(status_out, `TFA_SR_RESET);
        check(fault_out.fault, 1'b0);
        rd(EV, 32'h0);
        t_arrays();
        t_invalid();
        t_prot();
        t_first();
        t_assoc();
        t_refuse();
        t_hash();
        end_of_test();
    end
endmodule

// File: test/tfa_pipe_model.sv
// Pipeline stand-in: issues accesses and entry loads, captures faults
`timescale 1ns/1ps
module tfa_pipe_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench requests
    input wire logic issue,
    input wire logic load_req,
    input wire tfa_pkg::tfa_lookup_type req,
    // Unit side
    output tfa_pkg::tfa_lookup_type lookup,
    output logic entry_load_instr,
    input wire tfa_pkg::tfa_fault_type fault_out,
    // Last fault seen
    output logic seen,
    output tfa_pkg::tfa_fault_type got
);
    // No access right after an entry load, so the load settles first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lookup <= '0;
            entry_load_instr <= 1'b0;
            seen <= 1'b0;
            got <= '0;
        end else begin
            lookup <= (issue && !entry_load_instr) ? req : '0;
            entry_load_instr <= load_req;
            if (issue) begin
                seen <= 1'b0;
            end else if (fault_out.fault) begin
                seen <= 1'b1;
                got <= fault_out;
            end
        end
    end
endmodule

// File: verilog/tfa_core.sv
// Translation buffer fault logic and memory-mapped array access over APB
// How it works
// - Valid hit with access not allowed by access_rights_key raises a protection violation.
// - Protection violation loads event code 0A0 for loads, 0C0 for stores.
// - Protection violation and first-write faults record the faulting way in replace_way_counter.
// - Every fault stores the page number in entry high and full address in fault_address_reg.
// - saved_pc gets the faulting pc, or the delayed branch pc in a slot.
// - status_word goes to saved_status; privileged, mask and bank bits then set.
// - The fault vector is vector base plus 100 hex.
// - Address match on an entry whose valid bit is clear raises an invalid fault.
// - Invalid fault records the way and loads code 040 for loads, 060 for stores.
// - Write hitting a valid, permitted entry with written_page clear raises a first-write fault.
// - First-write fault always loads event code 080.
// - Privileged accesses at F2 reach the address array, at F3 the data array.
// - Arrays accept longwords only; the valid bit is visible through the data array.
// - Array address bits 16..12 index, 9..8 way, 31..24 select the array.
// - With hashing on, index is address bits 16..12 xor space id bits 4..0.
// - Associative write updates only the hitting way of four; misses do nothing.
// - Associative compare uses entry size, common bit, single space mode and privilege.
// - Non-associative address array write goes straight to the chosen index and way.
// - Address array read returns page, valid, space id; bits 16..12 read zero.
// - Data array access moves the entry low longword at the chosen index and way.
// - The event code sits in bits 11..0 of exception_event_reg.
`timescale 1ns/1ps
`include "tfa_defs.svh"

module tfa_core (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pipeline side
    input wire tfa_pkg::tfa_lookup_type lookup,
    input wire logic entry_load_instr,
    output tfa_pkg::tfa_fault_type fault_out,
    output logic [31:0] status_out
);

    // Buffer storage: 32 sets of 4 ways; valid bits kept apart so a flush clears them at once
    logic [29:0] addr_mem [0:127];
    logic [31:0] data_mem [0:127];
    logic [127:0] valid_q;

    // Software visible state
    logic [31:0] entry_high_q;
    logic [31:0] entry_low_q;
    logic [31:0] fault_addr_q;
    logic [31:0] xlat_ctrl_q;
    logic [11:0] exc_event_q;
    logic [31:0] saved_pc_q;
    logic [31:0] saved_status_q;
    logic [31:0] status_q;
    logic [31:0] vector_base_q;
    logic [31:0] rdata_q;
    logic ready_q;
    logic err_q;
    tfa_pkg::tfa_fault_type fault_q;

    // Compare one stored entry with a page number and space id
    function automatic logic tfa_match(input logic [29:0] ent, input logic [31:0] low, input logic [21:0] virtual_page_number,
                                       input logic [7:0] address_space_id, input logic sv, input logic md);
        logic small_page;
        logic shared;
        small_page = ~low[`TFA_EL_SIZE_HI] & ~low[`TFA_EL_SIZE_LO];
        shared = low[`TFA_EL_COMMON] | (sv & md);
        tfa_match = (ent[29:15] == virtual_page_number[21:7]) && (!small_page || ent[9:8] == virtual_page_number[1:0]) &&
                    (shared || ent[7:0] == address_space_id);
    endfunction

    // Set index, optionally hashed with the current space id
    function automatic logic [4:0] tfa_index(input logic [4:0] page_bits, input logic hash, input logic [4:0] address_space_id);
        tfa_index = hash ? (page_bits ^ address_space_id) : page_bits;
    endfunction

    // Control fields in use
    wire logic xlat_on = xlat_ctrl_q[`TFA_TCR_ENABLE];
    wire logic hash_on = xlat_ctrl_q[`TFA_TCR_HASH];
    wire logic single_space = xlat_ctrl_q[`TFA_TCR_SINGLE_SPACE];
    wire logic priv_mode = status_q[`TFA_SR_PRIV];
    wire logic [1:0] load_way = xlat_ctrl_q[`TFA_TCR_WAY_HI:`TFA_TCR_WAY_LO];
    wire logic [7:0] cur_address_space_id = entry_high_q[7:0];

    // Lookup of the pipeline access
    wire logic [4:0] lk_index = tfa_index(lookup.vaddr[16:12], hash_on, cur_address_space_id[4:0]);
    logic [3:0] lk_hit;
    logic [1:0] lk_way;
    logic lk_any;
    always_comb begin
        lk_hit = '0;
        for (int w = 0; w < 4; w++) begin
            lk_hit[w] = tfa_match(addr_mem[{lk_index, 2'(w)}], data_mem[{lk_index, 2'(w)}],
                                  lookup.vaddr[31:10], cur_address_space_id, single_space, priv_mode);
        end
    end
    assign lk_any = |lk_hit;
    assign lk_way = lk_hit[0] ? 2'h0 : lk_hit[1] ? 2'h1 : lk_hit[2] ? 2'h2 : 2'h3;

    // Classify the hit entry
    wire logic [31:0] lk_low = data_mem[{lk_index, lk_way}];
    wire logic lk_valid = valid_q[{lk_index, lk_way}];
    wire logic [1:0] lk_rights = lk_low[`TFA_EL_RIGHTS_HI:`TFA_EL_RIGHTS_LO];
    wire logic lk_denied = (!priv_mode && !lk_rights[1]) || (lookup.write && !lk_rights[0]);
    tfa_pkg::tfa_kind_type lk_kind;
    always_comb begin
        lk_kind = tfa_pkg::TFA_NONE;
        if (lookup.valid && xlat_on && lk_any) begin
            if (!lk_valid) begin
                lk_kind = tfa_pkg::TFA_INVALID;
            end else if (lk_denied) begin
                lk_kind = tfa_pkg::TFA_PROT;
            end else if (lookup.write && !lk_low[`TFA_EL_WRITTEN]) begin
                lk_kind = tfa_pkg::TFA_FIRST_WRITE;
            end
        end
    end

    // Event code for the fault kind
    logic [11:0] lk_code;
    always_comb begin
        unique case (lk_kind)
            tfa_pkg::TFA_PROT: lk_code = lookup.write ? `TFA_CODE_PROT_STORE : `TFA_CODE_PROT_LOAD;
            tfa_pkg::TFA_INVALID: lk_code = lookup.write ? `TFA_CODE_INVALID_STORE : `TFA_CODE_INVALID_LOAD;
            tfa_pkg::TFA_FIRST_WRITE: lk_code = `TFA_CODE_FIRST_WRITE;
            tfa_pkg::TFA_NONE: lk_code = '0;
        endcase
    end
    wire logic fault_now = (lk_kind != tfa_pkg::TFA_NONE);

    // APB decode; answer comes one cycle after setup
    wire logic setup = psel && !penable;
    wire logic access = psel && penable && ready_q;
    wire logic [7:0] sel = paddr[31:24];
    wire logic hit_aa = (sel == `TFA_SEL_ADDR_ARRAY);
    wire logic hit_da = (sel == `TFA_SEL_DATA_ARRAY);
    wire logic hit_ctrl = (sel == `TFA_SEL_CTRL);
    wire logic [23:0] off = paddr[23:0];
    wire logic ctrl_known = (off == `TFA_OFF_ENTRY_HIGH) || (off == `TFA_OFF_ENTRY_LOW) ||
                            (off == `TFA_OFF_FAULT_ADDR) || (off == `TFA_OFF_XLAT_CTRL) ||
                            (off == `TFA_OFF_EXC_EVENT) || (off == `TFA_OFF_SAVED_PC) ||
                            (off == `TFA_OFF_SAVED_STATUS) || (off == `TFA_OFF_STATUS) ||
                            (off == `TFA_OFF_VECTOR_BASE);
    wire logic full_word = !pwrite || (pstrb == 4'hF);
    wire logic array_ok = (hit_aa || hit_da) && pprot[0] && full_word;
    wire logic bus_ok = array_ok || (hit_ctrl && ctrl_known && pprot[0] && full_word);
    wire logic do_write = access && pwrite && !err_q;

    // Array entry selected by the bus address
    wire logic [4:0] aa_index = tfa_index(paddr[`TFA_AA_IDX_HI:`TFA_AA_IDX_LO], hash_on, cur_address_space_id[4:0]);
    wire logic [6:0] aa_slot = {aa_index, paddr[`TFA_AA_WAY_HI:`TFA_AA_WAY_LO]};
    wire logic assoc = paddr[`TFA_AA_ASSOC];

    // Associative write compare against all four ways
    logic [3:0] aw_hit;
    always_comb begin
        aw_hit = '0;
        for (int w = 0; w < 4; w++) begin
            aw_hit[w] = tfa_match(addr_mem[{aa_index, 2'(w)}], data_mem[{aa_index, 2'(w)}],
                                  pwdata[31:10], pwdata[7:0], single_space, priv_mode);
        end
    end
    wire logic [1:0] aw_way = aw_hit[0] ? 2'h0 : aw_hit[1] ? 2'h1 : aw_hit[2] ? 2'h2 : 2'h3;
    wire logic aa_wr = do_write && hit_aa;
    wire logic aa_wr_en = aa_wr && (!assoc || |aw_hit);
    wire logic [6:0] aa_wr_slot = assoc ? {aa_index, aw_way} : aa_slot;
    wire logic da_wr = do_write && hit_da;
    wire logic [6:0] ld_slot = {entry_high_q[16:12] ^ (hash_on ? cur_address_space_id[4:0] : 5'h00), load_way};

    // Read data mux
    wire logic [29:0] aa_ent = addr_mem[aa_slot];
    wire logic [31:0] aa_word = {aa_ent[29:15], 5'h00, aa_ent[9:8], 1'b0, valid_q[aa_slot], aa_ent[7:0]};
    wire logic [31:0] da_word = {data_mem[aa_slot][31:9], valid_q[aa_slot], data_mem[aa_slot][7:0]};
    logic [31:0] ctrl_word;
    always_comb begin
        ctrl_word = '0;
        unique case (off)
            `TFA_OFF_ENTRY_HIGH: ctrl_word = entry_high_q;
            `TFA_OFF_ENTRY_LOW: ctrl_word = entry_low_q;
            `TFA_OFF_FAULT_ADDR: ctrl_word = fault_addr_q;
            `TFA_OFF_XLAT_CTRL: ctrl_word = xlat_ctrl_q;
            `TFA_OFF_EXC_EVENT: ctrl_word = {20'h00000, exc_event_q};
            `TFA_OFF_SAVED_PC: ctrl_word = saved_pc_q;
            `TFA_OFF_SAVED_STATUS: ctrl_word = saved_status_q;
            `TFA_OFF_STATUS: ctrl_word = status_q;
            `TFA_OFF_VECTOR_BASE: ctrl_word = vector_base_q;
            default: ctrl_word = '0;
        endcase
    end
    wire logic [31:0] rd_word = !bus_ok ? 32'h0000_0000 : hit_aa ? aa_word : hit_da ? da_word : ctrl_word;

    // Bus answer: ready and error are loaded in setup, dropped after the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ready_q <= setup;
            err_q <= setup && !bus_ok;
            rdata_q <= (setup && !pwrite) ? rd_word : rdata_q;
        end
    end

    // Address and data arrays, written by bus or by the entry load
    always_ff @(posedge pclk) begin
        if (aa_wr_en) begin
            addr_mem[aa_wr_slot] <= {pwdata[31:10], pwdata[7:0]};
        end else if (entry_load_instr) begin
            addr_mem[ld_slot] <= {entry_high_q[31:10], entry_high_q[7:0]};
        end
        if (da_wr) begin
            data_mem[aa_slot] <= pwdata;
        end else if (entry_load_instr && !aa_wr_en) begin
            data_mem[ld_slot] <= entry_low_q;
        end
    end

    // Valid bits: flush clears all, either array path may set or clear one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_q <= '0;
        end else if (do_write && hit_ctrl && off == `TFA_OFF_XLAT_CTRL && pwdata[`TFA_TCR_FLUSH]) begin
            valid_q <= '0;
        end else if (aa_wr_en) begin
            valid_q[aa_wr_slot] <= pwdata[`TFA_EL_VALID];
        end else if (da_wr) begin
            valid_q[aa_slot] <= pwdata[`TFA_EL_VALID];
        end else if (entry_load_instr) begin
            valid_q[ld_slot] <= entry_low_q[`TFA_EL_VALID];
        end
    end

    // Plain control registers written by software only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_low_q <= '0;
            vector_base_q <= '0;
        end else if (do_write && hit_ctrl) begin
            entry_low_q <= (off == `TFA_OFF_ENTRY_LOW) ? pwdata : entry_low_q;
            vector_base_q <= (off == `TFA_OFF_VECTOR_BASE) ? pwdata : vector_base_q;
        end
    end

    // Registers the fault updates; a fault in the same cycle wins over software
    wire logic sw_ctrl = do_write && hit_ctrl;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_high_q <= '0;
            fault_addr_q <= '0;
            xlat_ctrl_q <= '0;
            exc_event_q <= `TFA_EVENT_RESET;
            saved_pc_q <= '0;
            saved_status_q <= '0;
            status_q <= `TFA_SR_RESET;
        end else if (fault_now) begin
            entry_high_q <= {lookup.vaddr[31:10], entry_high_q[9:0]};
            fault_addr_q <= lookup.vaddr;
            exc_event_q <= lk_code;
            saved_pc_q <= lookup.in_slot ? lookup.branch_pc : lookup.pc;
            saved_status_q <= status_q;
            status_q <= status_q | (32'h1 << `TFA_SR_PRIV) | (32'h1 << `TFA_SR_MASK) |
                        (32'h1 << `TFA_SR_BANK);
            xlat_ctrl_q[`TFA_TCR_WAY_HI:`TFA_TCR_WAY_LO] <= lk_way;
        end else if (sw_ctrl) begin
            entry_high_q <= (off == `TFA_OFF_ENTRY_HIGH) ? pwdata : entry_high_q;
            fault_addr_q <= (off == `TFA_OFF_FAULT_ADDR) ? pwdata : fault_addr_q;
            xlat_ctrl_q <= (off == `TFA_OFF_XLAT_CTRL) ? (pwdata & `TFA_TCR_MASK &
                           ~(32'h1 << `TFA_TCR_FLUSH)) : xlat_ctrl_q;
            exc_event_q <= (off == `TFA_OFF_EXC_EVENT) ? pwdata[11:0] : exc_event_q;
            saved_pc_q <= (off == `TFA_OFF_SAVED_PC) ? pwdata : saved_pc_q;
            saved_status_q <= (off == `TFA_OFF_SAVED_STATUS) ? pwdata : saved_status_q;
            status_q <= (off == `TFA_OFF_STATUS) ? pwdata : status_q;
        end
    end

    // Fault report to the pipeline: all fields valid in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= '0;
        end else begin
            fault_q.fault <= fault_now;
            fault_q.code <= lk_code;
            fault_q.way <= lk_way;
            fault_q.vector <= vector_base_q + `TFA_VECTOR_OFFSET;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign fault_out = fault_q;
    assign status_out = status_q;

endmodule

// File: verilog/tfa_defs.svh
// Offsets, field positions, reset values and exception codes of the translation fault unit
`ifndef TFA_DEFS_SVH
`define TFA_DEFS_SVH

// Array and control windows, selected by address bits 31..24
`define TFA_SEL_ADDR_ARRAY 8'hF2
`define TFA_SEL_DATA_ARRAY 8'hF3
`define TFA_SEL_CTRL 8'hFF

// Control register byte offsets inside the control window
`define TFA_OFF_ENTRY_HIGH 24'h000000
`define TFA_OFF_ENTRY_LOW 24'h000004
`define TFA_OFF_FAULT_ADDR 24'h00000C
`define TFA_OFF_XLAT_CTRL 24'h000010
`define TFA_OFF_EXC_EVENT 24'h000020
`define TFA_OFF_SAVED_PC 24'h000024
`define TFA_OFF_SAVED_STATUS 24'h000028
`define TFA_OFF_STATUS 24'h00002C
`define TFA_OFF_VECTOR_BASE 24'h000030

// Array access address fields
`define TFA_AA_IDX_HI 16
`define TFA_AA_IDX_LO 12
`define TFA_AA_WAY_HI 9
`define TFA_AA_WAY_LO 8
`define TFA_AA_ASSOC 7

// translation_control_reg fields
`define TFA_TCR_ENABLE 0
`define TFA_TCR_FLUSH 2
`define TFA_TCR_SINGLE_SPACE 8
`define TFA_TCR_HASH 9
`define TFA_TCR_WAY_HI 13
`define TFA_TCR_WAY_LO 12
`define TFA_TCR_MASK 32'h0000_3301

// status_word fields
`define TFA_SR_PRIV 30
`define TFA_SR_BANK 29
`define TFA_SR_MASK 28
`define TFA_SR_RESET 32'h7000_00F0

// Entry low word fields
`define TFA_EL_VALID 8
`define TFA_EL_SIZE_HI 7
`define TFA_EL_RIGHTS_HI 6
`define TFA_EL_RIGHTS_LO 5
`define TFA_EL_SIZE_LO 4
`define TFA_EL_WRITTEN 2
`define TFA_EL_COMMON 1

// Exception codes, bits 11..0 of exception_event_reg
`define TFA_CODE_INVALID_LOAD 12'h040
`define TFA_CODE_INVALID_STORE 12'h060
`define TFA_CODE_FIRST_WRITE 12'h080
`define TFA_CODE_PROT_LOAD 12'h0A0
`define TFA_CODE_PROT_STORE 12'h0C0
`define TFA_EVENT_RESET 12'h000
`define TFA_VECTOR_OFFSET 32'h0000_0100

`endif

// File: verilog/tfa_pkg.sv
// Types shared by the translation fault unit and its users
package tfa_pkg;

    // One access presented by the pipeline
    typedef struct packed {
        logic valid;
        logic write;
        logic in_slot;
        logic [31:0] vaddr;
        logic [31:0] pc;
        logic [31:0] branch_pc;
    } tfa_lookup_type;

    // Fault indication handed back to the pipeline
    typedef struct packed {
        logic fault;
        logic [11:0] code;
        logic [1:0] way;
        logic [31:0] vector;
    } tfa_fault_type;

    // Outcome of one lookup
    typedef enum logic [1:0] {
        TFA_NONE,
        TFA_PROT,
        TFA_INVALID,
        TFA_FIRST_WRITE
    } tfa_kind_type;

endpackage
